// File: logic/sac_pkg.sv
// Constants shared by the strap and graphics-port configuration block.
// Assumes a single bridge clock and one asynchronous active-low reset.
package sac_pkg;

  // ********************************************************************
  // Register byte offsets in configuration space, device 0 function 0
  // ********************************************************************
  localparam logic [7:0] OFS_STRAP_STATUS   = 8'h88;
  localparam logic [7:0] OFS_PCI_DRAM_TOP   = 8'h9c;
  localparam logic [7:0] OFS_GP_CAPABILITY  = 8'ha0;
  localparam logic [7:0] OFS_GP_STATUS      = 8'ha4;
  localparam logic [7:0] OFS_GP_COMMAND     = 8'ha8;

  // ********************************************************************
  // Strap status field positions
  // ********************************************************************
  localparam int STRAP_SIGNAL_TYPE_POS   = 25;
  localparam int STRAP_CLK_SPEED_LSB     = 20;
  localparam int STRAP_TRACE_LEN_LSB     = 16;
  localparam int STRAP_CLK_TO_PROC_POS   = 5;
  localparam int STRAP_CLK_FROM_PROC_POS = 4;
  localparam int STRAP_MULT_LSB          = 0;

  // Clock speed codes.
  localparam logic [1:0] CLK_SPEED_100   = 2'h0;
  localparam logic [1:0] CLK_SPEED_66    = 2'h1;
  localparam logic [1:0] CLK_SPEED_RSVD  = 2'h2;
  localparam logic [1:0] CLK_SPEED_133   = 2'h3;

  // Cycles that the pin synchronisers need to fill after reset release.
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // ********************************************************************
  // DRAM top, capability, status and command fields
  // ********************************************************************
  localparam int         DRAM_TOP_LSB        = 24;
  localparam logic [7:0] DRAM_TOP_RESET      = 8'h80;

  localparam int         CAP_MAJOR_LSB       = 20;
  localparam int         CAP_MINOR_LSB       = 16;
  localparam int         CAP_NEXT_LSB        = 8;
  localparam int         CAP_CODE_LSB        = 0;

  localparam int         STAT_QUEUE_LSB      = 24;
  localparam logic [7:0] STAT_QUEUE_RESET    = 8'h0f;
  localparam int         STAT_SIDEBAND_POS   = 9;
  localparam int         STAT_ABOVE_4G_POS   = 5;
  localparam int         STAT_FAST_WRITE_POS = 4;
  localparam int         STAT_RATE_LSB       = 0;

  localparam int         CMD_SIDEBAND_POS    = 9;
  localparam int         CMD_ACCEPT_POS      = 8;
  localparam int         CMD_ABOVE_4G_POS    = 5;
  localparam int         CMD_FAST_WRITE_POS  = 4;
  localparam int         CMD_MODE_LSB        = 0;
  localparam logic [2:0] CMD_MODE_RESET      = 3'h0;

  // ********************************************************************
  // Serial initialisation stream
  // ********************************************************************
  localparam int         INIT_FRAME_BITS     = 8;
  localparam int         INIT_BIT_DIV        = 16;

  typedef enum logic [1:0] {
    SAC_INIT_IDLE  = 2'h0,
    SAC_INIT_SHIFT = 2'h1,
    SAC_INIT_DONE  = 2'h3
  } sac_init_state_e;

endpackage

// File: logic/sac_strap_capture.sv
// Synchronises the strap pins and latches them once after reset release.
// Assumes the board holds the strap levels steady around reset release.
`timescale 1ns/1ps
module sac_strap_capture
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Strap pins
  input  wire logic [31:0] pad_ad,
  input  wire logic [3:0]  pad_cbe_n,
  // Captured straps
  output logic [31:0]      strap_word,
  output logic             strap_done
);

  logic [35:0] sync_a;
  logic [35:0] sync_b;
  logic [1:0]  settle;

  wire  [35:0] pad_bus = {pad_cbe_n, pad_ad};
  wire         capture = !strap_done && (settle == STRAP_SETTLE_CYCLES);
  // Test-only and general-purpose straps are not kept and read as zero.
  wire  [31:0] next_strap = {6'h00, sync_b[20], sync_b[4], sync_b[35], sync_b[34], sync_b[31:30], 2'h0,
                             sync_b[11:10], 8'h00, sync_b[32], 1'b0, sync_b[24], sync_b[8], sync_b[3:0]};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 36'h0;
      sync_b <= 36'h0;
    end else begin
      sync_a <= pad_bus;
      sync_b <= sync_a;
    end
  end

  // ********************************************************************
  // Wait for the synchronisers, then latch once
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      settle <= 2'h0;
    end else if (!strap_done && settle != STRAP_SETTLE_CYCLES) begin
      settle <= settle + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_word <= 32'h0;
      strap_done <= 1'b0;
    end else if (capture) begin
      strap_word <= next_strap; // [R1] [R2]
      strap_done <= 1'b1;
    end
  end

  strap_latch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    capture |=> strap_done && strap_word == $past(next_strap)) else $error("strap value not latched"); // [R1]
  strap_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    strap_done |=> $stable(strap_word) && strap_done) else $error("strap value changed after capture"); // [R2]

endmodule

// File: logic/sac_init_serializer.sv
// Sends one frame of strap-derived settings to the processor bus logic.
// Assumes a start pulse once per reset; later pulses during a frame are ignored.
`timescale 1ns/1ps
module sac_init_serializer
  import sac_pkg::*;
#(
  parameter int BIT_DIV = INIT_BIT_DIV
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  // Frame request
  input  wire logic                       start,
  input  wire logic [INIT_FRAME_BITS-1:0] frame,
  // Stream out
  output logic                            serial_init_stream,
  output logic                            serial_init_busy
);

  sac_init_state_e             state;
  sac_init_state_e             next_state;
  logic [INIT_FRAME_BITS-1:0]  shifter;
  logic [$clog2(INIT_FRAME_BITS+1)-1:0] bits_left;
  logic [$clog2(BIT_DIV)-1:0]  div_cnt;

  localparam logic [$clog2(BIT_DIV)-1:0] DIV_LAST = ($clog2(BIT_DIV))'(BIT_DIV - 1);
  localparam logic [$clog2(INIT_FRAME_BITS+1)-1:0] FRAME_LEN = ($clog2(INIT_FRAME_BITS+1))'(INIT_FRAME_BITS);

  wire bit_tick  = (div_cnt == DIV_LAST);
  wire last_bit  = bit_tick && (bits_left == 1);

  always_comb begin
    next_state = state;
    case (state)
      SAC_INIT_IDLE:  if (start) next_state = SAC_INIT_SHIFT;
      SAC_INIT_SHIFT: if (last_bit) next_state = SAC_INIT_DONE;
      SAC_INIT_DONE:  next_state = SAC_INIT_DONE;
      default:        next_state = SAC_INIT_IDLE;
    endcase
  end

  // ********************************************************************
  // Bit timing and shift register, most significant bit first
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= SAC_INIT_IDLE;
      shifter   <= '0;
      bits_left <= '0;
      div_cnt   <= '0;
    end else begin
      state <= next_state;
      if (state == SAC_INIT_IDLE && start) begin
        shifter   <= frame; // [R9]
        bits_left <= FRAME_LEN;
        div_cnt   <= '0;
      end else if (state == SAC_INIT_SHIFT) begin
        div_cnt <= bit_tick ? '0 : div_cnt + 1'b1;
        if (bit_tick) begin
          shifter   <= {shifter[INIT_FRAME_BITS-2:0], 1'b0};
          bits_left <= bits_left - 1'b1;
        end
      end
    end
  end

  assign serial_init_stream = (state == SAC_INIT_SHIFT) && shifter[INIT_FRAME_BITS-1];
  assign serial_init_busy   = (state == SAC_INIT_SHIFT);

  init_frame_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state == SAC_INIT_IDLE && start) |=> serial_init_busy [*8]) else $error("init frame ended early"); // [R9]

endmodule

// File: logic/sac_config_regs.sv
// Strap status, PCI DRAM top and graphics-port capability/status/command registers.
// Assumes a configuration access port already decoded to device 0, function 0.
// What the document requires
// [R1] Strap status register is read-only, each field from its own strap pin.
// [R2] Straps are latched once after reset and held until the next reset.
// [R3] Bit 25 reads 0 for a 1.5-V card, 1 for a 3.3-V card.
// [R4] Bits 21-20 give clock speed: 00 100 MHz, 01 66 MHz, 11 133 MHz.
// [R5] Bits 17-16 give processor trace length, 00 short, highest long.
// [R6] Bit 5 set means the block delays the clock sent to the processor.
// [R7] Bit 4 set means the processor delays the clock it returns.
// [R8] Four-bit multiplier code maps to 11.0-12.5 and 5.0-10.0 in half steps.
// [R9] Multiplier, clock speed and trace length form the serial initialisation stream.
// [R10] PCI master addresses below the DRAM top are claimed with DEVSEL#.
// [R11] Software programs the DRAM top only after sizing memory.
// [R12] Capability register is read-only: major, minor, next pointer, capability code.
// [R13] Status bits 31-24 give the request queue limit, fifteen at reset.
// [R14] Status bit 9 always reads 1, bit 5 always reads 0.
// [R15] Fast-write status reads 0 unless the fast-write override is set.
// [R16] Rate field reads 111; the 4x bit reads 0 under the 4x suppress.
// [R17] Fast writes run only with both override and command enable set.
// [R18] Command bit 8 set accepts graphics operations; clear ignores them.
// [R19] Command bit 9 enables or disables sideband addressing.
// [R20] Only 32-bit addresses; the above-4G enable reads 0 and is read-only.
// [R21] Software sets read target latency and clears the latency timer disable.
// [R22] Software sets exactly one transfer mode bit: 001, 010 or 100.
`timescale 1ns/1ps
module sac_config_regs
  import sac_pkg::*;
#(
  parameter logic [3:0] MAJOR_REVISION  = 4'h2,
  parameter logic [3:0] MINOR_REVISION  = 4'h0,
  parameter logic [7:0] NEXT_CAPABILITY = 8'h00,
  parameter logic [7:0] CAPABILITY_CODE = 8'h02,
  parameter logic [7:0] QUEUE_LIMIT     = STAT_QUEUE_RESET,
  parameter int         INIT_DIV        = INIT_BIT_DIV
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Configuration access
  input  wire logic        cfg_req,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_ack,
  // Strap pins
  input  wire logic [31:0] pad_ad,
  input  wire logic [3:0]  pad_cbe_n,
  // Compensation control bits held elsewhere
  input  wire logic        fast_write_override,
  input  wire logic        quad_rate_suppress,
  // PCI master address decode
  input  wire logic        pci_mem_cycle,
  input  wire logic [31:0] pci_master_addr,
  output logic             pci_devsel_claim,
  // Graphics port control
  input  wire logic        graphics_op_valid,
  output logic             graphics_op_taken,
  output logic             graphics_ops_accept,
  output logic             sideband_enable,
  output logic             fast_write_active,
  output logic [2:0]       transfer_mode,
  // Processor clocking and initialisation
  output logic             clock_to_processor_delay,
  output logic             clock_from_processor_delayed,
  output logic             serial_init_stream,
  output logic             serial_init_busy
);

  // ********************************************************************
  // Strap capture and initialisation stream
  // ********************************************************************
  logic [31:0] strap_status;
  logic        strap_done;
  logic        strap_done_q;

  sac_strap_capture u_strap (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .pad_ad     (pad_ad),
    .pad_cbe_n  (pad_cbe_n),
    .strap_word (strap_status),
    .strap_done (strap_done)
  );

  wire [3:0] proc_multiplier_field   = strap_status[STRAP_MULT_LSB +: 4];      // [R8]
  wire [1:0] clock_speed_strap       = strap_status[STRAP_CLK_SPEED_LSB +: 2]; // [R4]
  wire [1:0] proc_trace_length_strap = strap_status[STRAP_TRACE_LEN_LSB +: 2]; // [R5]
  wire       card_signal_type        = strap_status[STRAP_SIGNAL_TYPE_POS];    // [R3]
  wire       init_start              = strap_done && !strap_done_q;
  // The multiplier code travels raw; the receiving logic owns its table.
  wire [7:0] init_frame = {proc_trace_length_strap, clock_speed_strap, proc_multiplier_field}; // [R9]

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= strap_done;
    end
  end

  sac_init_serializer #(
    .BIT_DIV (INIT_DIV)
  ) u_init (
    .sys_clk            (sys_clk),
    .resetn             (resetn),
    .start              (init_start),
    .frame              (init_frame),
    .serial_init_stream (serial_init_stream),
    .serial_init_busy   (serial_init_busy)
  );

  // Clock delay choices only take effect once the straps are trusted.
  assign clock_to_processor_delay     = strap_status[STRAP_CLK_TO_PROC_POS];   // [R6]
  assign clock_from_processor_delayed = strap_status[STRAP_CLK_FROM_PROC_POS]; // [R7]

  // ********************************************************************
  // Writable state
  // ********************************************************************
  logic [7:0] dram_top;
  logic       cmd_sideband;
  logic       cmd_accept;
  logic       cmd_fast_write;
  logic [2:0] cmd_mode;

  wire wr_top = cfg_req && cfg_write && cfg_addr == OFS_PCI_DRAM_TOP && cfg_be[3];
  wire wr_cmd = cfg_req && cfg_write && cfg_addr == OFS_GP_COMMAND;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dram_top <= DRAM_TOP_RESET;
    end else if (wr_top) begin
      dram_top <= cfg_wdata[DRAM_TOP_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_sideband   <= 1'b0;
      cmd_accept     <= 1'b0;
      cmd_fast_write <= 1'b0;
      cmd_mode       <= CMD_MODE_RESET;
    end else if (wr_cmd) begin
      if (cfg_be[1]) begin
        cmd_sideband <= cfg_wdata[CMD_SIDEBAND_POS]; // [R19]
        cmd_accept   <= cfg_wdata[CMD_ACCEPT_POS];   // [R18]
      end
      if (cfg_be[0]) begin
        cmd_fast_write <= cfg_wdata[CMD_FAST_WRITE_POS];
        cmd_mode       <= cfg_wdata[CMD_MODE_LSB +: 3];
      end
    end
  end

  // ********************************************************************
  // Read views
  // ********************************************************************
  wire [31:0] cap_word = {8'h00, MAJOR_REVISION, MINOR_REVISION, NEXT_CAPABILITY, CAPABILITY_CODE}; // [R12]

  wire [2:0]  rate_field = {!quad_rate_suppress, 2'h3}; // [R16]
  wire [31:0] status_word = (32'(QUEUE_LIMIT) << STAT_QUEUE_LSB)  // [R13]
                          | (32'h1 << STAT_SIDEBAND_POS)          // [R14]
                          | (32'(fast_write_override) << STAT_FAST_WRITE_POS) // [R15]
                          | (32'(rate_field) << STAT_RATE_LSB);

  // The above-4G enable is never stored, so it always reads zero.
  wire [31:0] command_word = (32'(cmd_sideband) << CMD_SIDEBAND_POS)
                           | (32'(cmd_accept) << CMD_ACCEPT_POS)
                           | (32'(cmd_fast_write) << CMD_FAST_WRITE_POS)
                           | (32'(cmd_mode) << CMD_MODE_LSB); // [R20]

  wire [31:0] top_word = {dram_top, 24'h000000};

  // Unmapped offsets read zero, and writes to them or to read-only words do nothing.
  wire [31:0] read_mux = (cfg_addr == OFS_STRAP_STATUS)  ? strap_status :
                         (cfg_addr == OFS_PCI_DRAM_TOP)  ? top_word     :
                         (cfg_addr == OFS_GP_CAPABILITY) ? cap_word     :
                         (cfg_addr == OFS_GP_STATUS)     ? status_word  :
                         (cfg_addr == OFS_GP_COMMAND)    ? command_word : 32'h0;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 32'h0;
      cfg_ack   <= 1'b0;
    end else begin
      cfg_ack <= cfg_req;
      if (cfg_req && !cfg_write) begin
        cfg_rdata <= read_mux; // [R1]
      end
    end
  end

  // ********************************************************************
  // Address claim and graphics port controls
  // ********************************************************************
  // Only the top byte is compared, so the DRAM region ends on a 16-Mbyte boundary.
  wire in_dram = pci_master_addr[31:24] < dram_top;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pci_devsel_claim <= 1'b0;
    end else begin
      pci_devsel_claim <= pci_mem_cycle && in_dram; // [R10]
    end
  end

  assign graphics_ops_accept = cmd_accept;
  assign graphics_op_taken   = graphics_op_valid && cmd_accept; // [R18]
  assign sideband_enable     = cmd_sideband;                    // [R19]
  assign fast_write_active   = fast_write_override && cmd_fast_write; // [R17]
  assign transfer_mode       = cmd_mode;

  // ********************************************************************
  // Checks
  // ********************************************************************
  // Reads are checked one cycle on, where the registered data stands.
  sequence cmd_write_s;
    wr_cmd && cfg_be[1];
  endsequence

  sequence low_lane_write_s;
    wr_cmd && cfg_be[0];
  endsequence

  sequence top_write_s;
    wr_top;
  endsequence

  sequence claim_hit_s;
    pci_mem_cycle && pci_master_addr[31:24] < dram_top;
  endsequence

  sequence read_of_s(logic [7:0] ofs);
    cfg_req && !cfg_write && cfg_addr == ofs;
  endsequence

  signal_type_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
    read_of_s(OFS_STRAP_STATUS) |=> cfg_ack && cfg_rdata[25] == $past(card_signal_type))
    else $error("strap read wrong");

  strap_spare_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R1]
    read_of_s(OFS_STRAP_STATUS) |=> (cfg_rdata & 32'hfc0cff40) == 32'h0)
    else $error("spare strap bits set");

  ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cfg_ack == $past(cfg_req))
    else $error("ack not one cycle after request");

  queue_limit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R13]
    read_of_s(OFS_GP_STATUS) |=> cfg_rdata[31:24] == QUEUE_LIMIT)
    else $error("queue limit wrong");

  fixed_status_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R14]
    read_of_s(OFS_GP_STATUS) |=> cfg_rdata[9] && !cfg_rdata[5])
    else $error("fixed status bits wrong");

  fast_status_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R15]
    read_of_s(OFS_GP_STATUS) |=> cfg_rdata[4] == $past(fast_write_override))
    else $error("fast status wrong");

  rate_field_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R16]
    read_of_s(OFS_GP_STATUS) |=> cfg_rdata[2:0] == {!$past(quad_rate_suppress), 2'h3})
    else $error("rates wrong");

  fast_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R17]
    low_lane_write_s |=> fast_write_active == ($past(cfg_wdata[CMD_FAST_WRITE_POS]) && fast_write_override))
    else $error("fast write gate wrong");

  accept_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R18] [R19]
    cmd_write_s |=> graphics_ops_accept == $past(cfg_wdata[8]) && sideband_enable == $past(cfg_wdata[9]))
    else $error("command bits not taken");

  ignore_ops_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R18]
    !graphics_ops_accept |-> !graphics_op_taken)
    else $error("operation taken while disabled");

  above_4g_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R20]
    read_of_s(OFS_GP_COMMAND) |=> !cfg_rdata[5])
    else $error("above 4G enable reads one");

  top_write_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
    top_write_s |=> dram_top == $past(cfg_wdata[DRAM_TOP_LSB +: 8]))
    else $error("DRAM top not stored");

  dram_claim_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
    claim_hit_s |=> pci_devsel_claim)
    else $error("DRAM hit not claimed");

  no_claim_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
    (pci_master_addr[31:24] >= dram_top) |=> !pci_devsel_claim)
    else $error("claim above DRAM top");

  claim_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
    !pci_mem_cycle |=> !pci_devsel_claim)
    else $error("claim without memory cycle");

  init_start_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R9]
    init_start |=> serial_init_busy)
    else $error("init stream did not start");

endmodule

// File: test/sac_pci_board.sv
// Board straps and an external PCI master facing the config block.
// Assumes the bench drives go and addr just after a falling edge.
`timescale 1ns/1ps
module sac_pci_board
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Strap levels and master request
  input  wire logic [31:0] strap_ad,
  input  wire logic [3:0]  strap_cbe_n,
  input  wire logic        go,
  input  wire logic [31:0] addr,
  // Pins
  output logic [31:0]      pad_ad,
  output logic [3:0]       pad_cbe_n,
  output logic             pci_mem_cycle,
  output logic [31:0]      pci_master_addr
);
  logic [7:0]  cnt;
  logic [31:0] last;
  wire         hold = !resetn || cnt < 8'h08;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
  end
  always_ff @(posedge sys_clk) begin
    if (go) last <= addr;
  end
  // Straps stay put around reset, then the bus carries changing traffic.
  assign pad_ad          = hold ? strap_ad : ~strap_ad ^ {4{cnt}};
  assign pad_cbe_n       = hold ? strap_cbe_n : ~strap_cbe_n ^ cnt[3:0];
  assign pci_mem_cycle   = go;
  // A released address bus shows the inverse of its last value.
  assign pci_master_addr = go ? addr : ~last;
endmodule

// File: test/tb_top.sv
// Self-checking bench for the strap and graphics-port config registers.
// Assumes the one-cycle config handshake and INIT_DIV of 2.
`timescale 1ns/1ps
module tb_top;
  import sac_pkg::*;
  logic        sys_clk = 0, resetn = 0, cfg_req = 0, cfg_write = 0, go = 0;
  logic        fast_write_override = 0, quad_rate_suppress = 0, graphics_op_valid = 0;
  logic [7:0]  cfg_addr = 0, fr;
  logic [3:0]  cfg_be = 0, s_cbe = 0;
  logic [31:0] cfg_wdata = 0, s_ad = 0, addr = 0, rd, st, w, top;
  logic [2:0]  m;
  wire  [31:0] cfg_rdata, pad_ad, pci_master_addr;
  wire  [3:0]  pad_cbe_n;
  wire  [2:0]  transfer_mode;
  wire         cfg_ack, pci_mem_cycle, pci_devsel_claim, graphics_op_taken, graphics_ops_accept;
  wire         sideband_enable, fast_write_active, clk_to, clk_from, serial_init_stream, serial_init_busy;
  int          failures = 0, n_tests = 0;

  sac_config_regs #(.INIT_DIV(2)) u_sac_config_regs (.sys_clk(sys_clk), .resetn(resetn),
    .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .pad_ad(pad_ad),
    .pad_cbe_n(pad_cbe_n), .fast_write_override(fast_write_override),
    .quad_rate_suppress(quad_rate_suppress), .pci_mem_cycle(pci_mem_cycle),
    .pci_master_addr(pci_master_addr), .pci_devsel_claim(pci_devsel_claim),
    .graphics_op_valid(graphics_op_valid), .graphics_op_taken(graphics_op_taken),
    .graphics_ops_accept(graphics_ops_accept), .sideband_enable(sideband_enable),
    .fast_write_active(fast_write_active), .transfer_mode(transfer_mode),
    .clock_to_processor_delay(clk_to), .clock_from_processor_delayed(clk_from),
    .serial_init_stream(serial_init_stream), .serial_init_busy(serial_init_busy));
  sac_pci_board u_sac_pci_board (.sys_clk(sys_clk), .resetn(resetn), .strap_ad(s_ad),
    .strap_cbe_n(s_cbe), .go(go), .addr(addr), .pad_ad(pad_ad), .pad_cbe_n(pad_cbe_n),
    .pci_mem_cycle(pci_mem_cycle), .pci_master_addr(pci_master_addr));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One-cycle request; the answer is taken at the next falling edge, then one idle cycle passes.
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_req = 1; cfg_write = wr; cfg_addr = a; cfg_be = be; cfg_wdata = d;
    @(negedge sys_clk);
    chk(cfg_ack, 1, "ack");
    rd = cfg_rdata;
    cfg_req = 0;
    @(negedge sys_clk);
    chk(cfg_ack, 0, "ack pulse");
  endtask

  function automatic logic [31:0] exp_strap(input logic [31:0] a, input logic [3:0] c);
    logic [31:0] e;
    e = 0;
    e[25] = a[20]; e[24] = a[4]; e[23] = c[3]; e[22] = c[2]; e[21:20] = a[31:30];
    e[17:16] = a[11:10]; e[7] = c[0]; e[5] = a[24]; e[4] = a[8]; e[3:0] = a[3:0];
    return e;
  endfunction

  task automatic print_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #25000;
    failures++;
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hfd5abe40));
    s_ad = $urandom;
    s_cbe = $urandom;
    repeat (16) @(negedge sys_clk);
    resetn = 1;
    fr = {s_ad[11:10], s_ad[31:30], s_ad[3:0]};
    for (int i = 0; i < 40 && serial_init_busy !== 1'b1; i++) @(negedge sys_clk);
    for (int i = 7; i >= 0; i--) begin
      chk(serial_init_stream, fr[i], "init bit");
      repeat (2) @(negedge sys_clk);
    end
    chk({serial_init_busy, serial_init_stream}, 0, "init idle");
    st = exp_strap(s_ad, s_cbe);
    cfg(0, OFS_STRAP_STATUS, 0, 0); chk(rd, st, "straps");
    chk({clk_to, clk_from}, {st[5], st[4]}, "clock delay");
    cfg(1, OFS_STRAP_STATUS, 4'hf, ~st); cfg(0, OFS_STRAP_STATUS, 0, 0); chk(rd, st, "strap hold");
    cfg(0, OFS_GP_CAPABILITY, 0, 0); chk(rd, 32'h00200002, "capability");
    for (int i = 0; i < 4; i++) begin
      {fast_write_override, quad_rate_suppress} = i[1:0];
      cfg(1, OFS_GP_STATUS, 4'hf, 0); cfg(0, OFS_GP_STATUS, 0, 0);
      chk(rd, {8'h0f, 14'h0, 1'b1, 3'h0, 1'b0, i[1], 1'b0, ~i[0], 2'h3}, "status");
    end
    cfg(0, OFS_GP_COMMAND, 0, 0); chk(rd, 0, "cmd reset");
    foreach (m[k]) begin
      w = ($urandom & 32'hfffffff8) | (32'h1 << k);
      fast_write_override = $urandom;
      graphics_op_valid = 1;
      cfg(1, OFS_GP_COMMAND, 4'hf, w); cfg(0, OFS_GP_COMMAND, 0, 0);
      chk(rd, w & 32'h00000317, "cmd");
      chk({sideband_enable, graphics_ops_accept, graphics_op_taken}, {w[9], w[8], w[8]}, "enables");
      chk(fast_write_active, fast_write_override & w[4], "fast write");
      chk(transfer_mode, w[2:0], "mode");
    end
    cfg(1, OFS_GP_COMMAND, 4'h2, 0); chk(transfer_mode, w[2:0], "lane");
    chk({sideband_enable, graphics_op_taken}, 0, "lane off");
    cfg(0, 8'h90, 0, 0); chk(rd, 0, "unmapped");
    cfg(0, OFS_PCI_DRAM_TOP, 0, 0); chk(rd, 32'h80000000, "top reset");
    top = $urandom | 32'h01000000;
    cfg(1, OFS_PCI_DRAM_TOP, 4'hf, top); cfg(0, OFS_PCI_DRAM_TOP, 0, 0);
    chk(rd, top & 32'hff000000, "top");
    cfg(1, OFS_PCI_DRAM_TOP, 4'h7, 0); cfg(0, OFS_PCI_DRAM_TOP, 0, 0);
    chk(rd, top & 32'hff000000, "top lane");
    // Master traffic is PCI-to-memory only, so the arbiter deadlock settings stay with software.
    for (int i = 0; i < 24; i++) begin
      addr = (i == 0) ? {top[31:24], 24'h0} : (i == 1) ? {top[31:24] - 8'h1, 24'hffffff} : $urandom;
      go = (i != 2);
      @(negedge sys_clk);
      chk(pci_devsel_claim, (i != 2) && addr[31:24] < top[31:24], "claim");
    end
    go = 0;
    resetn = 0;
    s_ad = $urandom;
    s_cbe = $urandom;
    repeat (2) @(negedge sys_clk);
    resetn = 1;
    repeat (8) @(negedge sys_clk);
    cfg(0, OFS_STRAP_STATUS, 0, 0); chk(rd, exp_strap(s_ad, s_cbe), "recapture");
    print_verdict();
  end
endmodule
